// file: hdl/iosp_top.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
// ==========================================
// status publisher and output subscriber
// Contract
// - published frames go to 01-0C-CD-01 plus two configurable octets.
// - priority, virtual_lan_identifier, refs, live time and message id are settings sent.
// - with no change the frame repeats every heartbeat, default 2000 ms.
// - no subscribed frame for three seconds zeroes outputs, subscription inactive.
// - each signal is sent as state then quality.
// - any state or quality change sends a frame at once.
// - dataset order is health, inputs 1 to 14, outputs 1 to 4.
// - health state true when fine, false in alarm.
// - input state true when the input is activated.
// - output state true when activated, in both directions.
// - quality is a bitstring, all zeros meaning good.
// - outputs follow only frames from the configured commanding device.
// - a received signal with bad quality counts as off.
module iosp_top #(
	parameter int CYC_PER_MS = iosp_pkg::CYC_PER_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        health_ok_pin,
	input  wire logic [13:0] di_pin,
	input  wire logic [13:0] di_fault_pin,
	output logic [3:0]       do_pin,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_last,
	input  wire logic        tx_ready,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	output logic             irq
);
	import iosp_pkg::*;
	localparam int TW = $clog2(CYC_PER_MS + 1);

	logic [NIN-1:0] di_m_r;
	logic [NIN-1:0] di_s_r;
	logic [NIN-1:0] flt_m_r;
	logic [NIN-1:0] flt_s_r;
	logic           hl_m_r;
	logic           hl_s_r;
	logic [TW-1:0]  tick_r;
	logic           ms_tick;
	logic           pub_en_r;
	iosp_hdr_t      hdr_r;
	logic [15:0]    hbeat_r;
	logic [15:0]    src_r;
	logic [3:0]     ist_r;
	logic [3:0]     imask_r;
	logic [15:0]    tx_cnt_r;
	logic [15:0]    rx_cnt_r;
	logic [15:0]    hb_ms_r;
	logic [15:0]    sup_ms_r;
	logic           act_r;
	logic [3:0]     do_r;
	logic [3:0]     do_nxt;
	iosp_ds_t       ds;
	iosp_ds_t       snap_r;
	iosp_cmd_t      cmd;
	logic           wr;
	logic           setup;
	logic [31:0]    rd_val;
	logic           rd_err;
	logic [3:0]     ev;
	logic           change;
	logic           hb_due;
	logic           start;
	logic           busy;
	logic           done;
	logic           rx_ok;
	logic           rx_rej;
	logic           sup_to;

	// ==========================================
	// pin synchronisers
	// the first stage feeds only the second, never logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			di_m_r  <= '0;
			di_s_r  <= '0;
			flt_m_r <= '0;
			flt_s_r <= '0;
			hl_m_r  <= 1'b0;
			hl_s_r  <= 1'b0;
		end else begin
			di_m_r  <= di_pin;
			di_s_r  <= di_m_r;
			flt_m_r <= di_fault_pin;
			flt_s_r <= flt_m_r;
			hl_m_r  <= health_ok_pin;
			hl_s_r  <= hl_m_r;
		end
	end

	// ==========================================
	// millisecond time base
	assign ms_tick = (tick_r == TW'(CYC_PER_MS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tick_r <= '0;
		else tick_r <= ms_tick ? '0 : tick_r + 1'b1;
	end

	// ==========================================
	// apb slave, zero wait states
	assign pready = 1'b1;
	assign setup  = psel && !penable;
	assign wr     = psel && penable && pwrite;

	// writable settings: frame header fields plus control, heartbeat, subscription source and interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pub_en_r <= 1'b1;
			hdr_r    <= '0;
			hdr_r.tal <= TAL_RST;
			hbeat_r  <= HB_RST;
			src_r    <= 16'h0000;
			imask_r  <= 4'h0;
		end else if (wr) begin
			case (paddr)
				OFS_CTRL:   pub_en_r    <= pwdata[0];
				OFS_DEST:   hdr_r.dst   <= pwdata[15:0];
				OFS_VLAN: begin
					hdr_r.prio <= pwdata[2:0];
					hdr_r.vid  <= pwdata[VID_LSB +: 12];
				end
				OFS_CBREF:  hdr_r.cbref <= pwdata[15:0];
				OFS_TAL:    hdr_r.tal   <= pwdata[15:0];
				OFS_HBEAT:  hbeat_r     <= pwdata[15:0];
				OFS_DSREF:  hdr_r.dsref <= pwdata[15:0];
				OFS_MSGID:  hdr_r.msgid <= pwdata[15:0];
				OFS_SUBSRC: src_r       <= pwdata[15:0];
				OFS_IMASK:  imask_r     <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets answer with an error and zero data
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			OFS_CTRL:   rd_val = {31'h0, pub_en_r};
			OFS_DEST:   rd_val = {16'h0, hdr_r.dst};
			OFS_VLAN:   rd_val = {4'h0, hdr_r.vid, 13'h0, hdr_r.prio};
			OFS_CBREF:  rd_val = {16'h0, hdr_r.cbref};
			OFS_TAL:    rd_val = {16'h0, hdr_r.tal};
			OFS_HBEAT:  rd_val = {16'h0, hbeat_r};
			OFS_DSREF:  rd_val = {16'h0, hdr_r.dsref};
			OFS_MSGID:  rd_val = {16'h0, hdr_r.msgid};
			OFS_SUBSRC: rd_val = {16'h0, src_r};
			OFS_STAT: begin
				rd_val[0]               = act_r;
				rd_val[STAT_DO +: 4]    = do_r;
				rd_val[STAT_BSY]        = busy;
			end
			OFS_ISTAT:  rd_val = {28'h0, ist_r};
			OFS_IMASK:  rd_val = {28'h0, imask_r};
			OFS_CNT:    rd_val = {rx_cnt_r, tx_cnt_r};
			default:    rd_err = 1'b1;
		endcase
	end

	// read data is caught in the setup cycle so it leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr <= rd_err;
		end
	end

	// ==========================================
	// published dataset
	always_comb begin
		ds.st[0] = hl_s_r;
		ds.q[0]  = QUAL_GOOD;
		for (int i = 0; i < NIN; i++) begin
			ds.st[1+i] = di_s_r[i];
			ds.q[1+i]  = flt_s_r[i] ? QUAL_INV : QUAL_GOOD;
		end
		for (int j = 0; j < NOUT; j++) begin
			ds.st[1+NIN+j] = do_r[j];
			ds.q[1+NIN+j]  = act_r ? QUAL_GOOD : QUAL_INV;
		end
	end

	// ==========================================
	// publish scheduling
	// a change stays pending until sent, since the snapshot only moves on start
	assign change = (ds != snap_r);
	assign hb_due = (hb_ms_r >= hbeat_r);
	assign start  = !busy && pub_en_r && (change || hb_due);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_r  <= '0;
			hb_ms_r <= 16'h0000;
		end else if (start) begin
			snap_r  <= ds;
			hb_ms_r <= 16'h0000;
		end else if (ms_tick && !hb_due) begin
			hb_ms_r <= hb_ms_r + 16'h0001;
		end
	end

	// ==========================================
	// subscription supervision and outputs
	always_comb begin
		for (int k = 0; k < NOUT; k++) begin
			do_nxt[k] = cmd.st[k] && !iosp_qbad(cmd.q[k]);
		end
	end

	assign sup_to = act_r && ms_tick && (sup_ms_r == 16'(SUP_MS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_r    <= 1'b0;
			sup_ms_r <= 16'h0000;
			do_r     <= 4'h0;
		end else if (rx_ok) begin
			act_r    <= 1'b1;
			sup_ms_r <= 16'h0000;
			do_r     <= do_nxt;
		end else if (sup_to) begin
			act_r    <= 1'b0;
			sup_ms_r <= 16'h0000;
			do_r     <= 4'h0;
		end else if (act_r && ms_tick) begin
			sup_ms_r <= sup_ms_r + 16'h0001;
		end
	end

	assign do_pin = do_r;

	// ==========================================
	// interrupts and counters
	// a new event beats a write-one-clear in the same cycle
	assign ev[IRQ_SENT] = done;
	assign ev[IRQ_TMO]  = sup_to;
	assign ev[IRQ_UP]   = rx_ok && !act_r;
	assign ev[IRQ_REJ]  = rx_rej;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_r    <= 4'h0;
			tx_cnt_r <= 16'h0000;
			rx_cnt_r <= 16'h0000;
		end else begin
			ist_r <= (ist_r & ~((wr && paddr == OFS_ISTAT) ? pwdata[3:0] : 4'h0)) | ev;
			if (done) tx_cnt_r <= tx_cnt_r + 16'h0001;
			if (rx_ok) rx_cnt_r <= rx_cnt_r + 16'h0001;
		end
	end

	assign irq = |(ist_r & imask_r);

	// ==========================================
	// submodules
	iosp_tx_ser u_ser (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (start),
		.hdr      (hdr_r),
		.ds       (ds),
		.busy     (busy),
		.done     (done),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.tx_last  (tx_last),
		.tx_ready (tx_ready)
	);

	iosp_rx_sub u_rx (
		.pclk     (pclk),
		.presetn  (presetn),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_last  (rx_last),
		.src_id   (src_r),
		.cmd      (cmd),
		.ok       (rx_ok),
		.rej      (rx_rej)
	);

	// ==========================================
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	timeout_zero_a: assert property (sup_to && !rx_ok |=> !act_r && do_pin == 4'h0)
		else $error("timeout did not clear outputs");
	stay_off_a: assert property (!act_r && !rx_ok |=> !act_r && do_pin == 4'h0)
		else $error("inactive subscription drove outputs");
	sub_restart_a: assert property (rx_ok |=> act_r && sup_ms_r == 16'h0000)
		else $error("supervision not restarted");
	bad_qual_a: assert property (rx_ok && iosp_qbad(cmd.q[0]) |=> !do_pin[0])
		else $error("bad quality output turned on");
	out_source_a: assert property (do_pin != $past(do_pin) |-> $past(rx_ok) || $past(sup_to))
		else $error("outputs moved without a frame");
	change_send_a: assert property (change && !busy && pub_en_r |=> busy)
		else $error("change not sent at once");
	heartbeat_a: assert property (hb_due && !busy && pub_en_r |=> busy && hb_ms_r == 16'h0000)
		else $error("heartbeat frame not sent");
	sticky_tmo_a: assert property (sup_to |=> ist_r[IRQ_TMO])
		else $error("timeout flag lost");

	sent_c: cover property (start ##[1:200] done);
	timeout_c: cover property (sup_to);
	restore_c: cover property (rx_ok && !act_r);
	reject_c: cover property (rx_rej);
endmodule : iosp_top

// file: include/iosp_pkg.sv
// ==========================================
// shared constants and carriers
package iosp_pkg;
	localparam int NIN      = 14;
	localparam int NOUT     = 4;
	localparam int NSIG     = 1 + NIN + NOUT;
	localparam int QW       = 13;
	localparam int HDR_B    = 16;
	localparam int NBYTES   = HDR_B + NSIG * 3;
	localparam int RX_B     = 2 + NOUT * 3;
	localparam logic [QW-1:0] QUAL_GOOD = 13'h0000;
	localparam logic [QW-1:0] QUAL_INV  = 13'h0001;
	localparam logic [31:0] DEST_FIXED  = 32'h010CCD01;
	// timing
	localparam int CLK_NS     = 10;
	localparam int MS_NS      = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	localparam int HBEAT_MS   = 2000;
	localparam int SUP_MS     = 3000;
	// register offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_DEST  = 8'h04;
	localparam logic [7:0] OFS_VLAN  = 8'h08;
	localparam logic [7:0] OFS_CBREF = 8'h0C;
	localparam logic [7:0] OFS_TAL   = 8'h10;
	localparam logic [7:0] OFS_HBEAT = 8'h14;
	localparam logic [7:0] OFS_DSREF = 8'h18;
	localparam logic [7:0] OFS_MSGID = 8'h1C;
	localparam logic [7:0] OFS_SUBSRC= 8'h20;
	localparam logic [7:0] OFS_STAT  = 8'h24;
	localparam logic [7:0] OFS_ISTAT = 8'h28;
	localparam logic [7:0] OFS_IMASK = 8'h2C;
	localparam logic [7:0] OFS_CNT   = 8'h30;
	// fields and reset values
	localparam int VID_LSB  = 16;
	localparam int STAT_DO  = 4;
	localparam int STAT_BSY = 8;
	localparam int IRQ_SENT = 0;
	localparam int IRQ_TMO  = 1;
	localparam int IRQ_UP   = 2;
	localparam int IRQ_REJ  = 3;
	localparam logic [15:0] TAL_RST = 16'h0FA0;
	localparam logic [15:0] HB_RST  = 16'(HBEAT_MS);

	typedef struct packed {
		logic [15:0] dst;
		logic [2:0]  prio;
		logic [11:0] vid;
		logic [15:0] cbref;
		logic [15:0] tal;
		logic [15:0] dsref;
		logic [15:0] msgid;
	} iosp_hdr_t;
	typedef struct packed {
		logic [NSIG-1:0]         st;
		logic [NSIG-1:0][QW-1:0] q;
	} iosp_ds_t;
	typedef struct packed {
		logic [NOUT-1:0]         st;
		logic [NOUT-1:0][QW-1:0] q;
	} iosp_cmd_t;

	// any set quality bit means not good
	function automatic logic iosp_qbad(input logic [QW-1:0] q);
		return |q;
	endfunction : iosp_qbad
endpackage : iosp_pkg

// file: hdl/iosp_tx_ser.sv
`timescale 1ns/1ps
// ==========================================
// frame serializer
module iosp_tx_ser (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               start,
	input  wire iosp_pkg::iosp_hdr_t hdr,
	input  wire iosp_pkg::iosp_ds_t  ds,
	output logic                    busy,
	output logic                    done,
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	output logic                    tx_last,
	input  wire logic               tx_ready
);
	import iosp_pkg::*;
	typedef enum logic [1:0] {S_IDLE, S_HDR, S_DATA} iosp_ser_t;
	iosp_ser_t st_r;
	iosp_hdr_t hdr_r;
	iosp_ds_t  ds_r;
	logic [6:0] idx_r;
	logic [4:0] sig_r;
	logic [1:0] part_r;
	logic       adv;
	logic [15:0] tci;

	assign busy     = (st_r != S_IDLE);
	assign tx_valid = busy;
	assign adv      = tx_valid && tx_ready;
	assign tx_last  = (st_r == S_DATA) && (sig_r == 5'(NSIG-1)) && (part_r == 2'h2);
	assign tci      = {hdr_r.prio, 1'b0, hdr_r.vid};

	// contents latched at start so the frame is one coherent snapshot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r   <= S_IDLE;
			hdr_r  <= '0;
			ds_r   <= '0;
			idx_r  <= 7'h00;
			sig_r  <= 5'h00;
			part_r <= 2'h0;
			done   <= 1'b0;
		end else begin
			done <= adv && tx_last;
			unique case (st_r)
				S_IDLE: if (start) begin
					st_r  <= S_HDR;
					hdr_r <= hdr;
					ds_r  <= ds;
					idx_r <= 7'h00;
				end
				S_HDR: if (adv) begin
					idx_r  <= idx_r + 7'h01;
					sig_r  <= 5'h00;
					part_r <= 2'h0;
					if (idx_r == 7'(HDR_B-1)) st_r <= S_DATA;
				end
				S_DATA: if (adv) begin
					idx_r  <= idx_r + 7'h01;
					part_r <= (part_r == 2'h2) ? 2'h0 : part_r + 2'h1;
					if (part_r == 2'h2) sig_r <= sig_r + 5'h01;
					if (tx_last) st_r <= S_IDLE;
				end
			endcase
		end
	end

	// byte mux: fixed dest octets, settings, then state/quality pairs
	always_comb begin
		tx_data = 8'h00;
		if (st_r == S_HDR) begin
			unique case (idx_r[3:0])
				4'h0: tx_data = DEST_FIXED[31:24];
				4'h1: tx_data = DEST_FIXED[23:16];
				4'h2: tx_data = DEST_FIXED[15:8];
				4'h3: tx_data = DEST_FIXED[7:0];
				4'h4: tx_data = hdr_r.dst[15:8];
				4'h5: tx_data = hdr_r.dst[7:0];
				4'h6: tx_data = tci[15:8];
				4'h7: tx_data = tci[7:0];
				4'h8: tx_data = hdr_r.cbref[15:8];
				4'h9: tx_data = hdr_r.cbref[7:0];
				4'hA: tx_data = hdr_r.tal[15:8];
				4'hB: tx_data = hdr_r.tal[7:0];
				4'hC: tx_data = hdr_r.dsref[15:8];
				4'hD: tx_data = hdr_r.dsref[7:0];
				4'hE: tx_data = hdr_r.msgid[15:8];
				4'hF: tx_data = hdr_r.msgid[7:0];
			endcase
		end else if (st_r == S_DATA) begin
			case (part_r)
				2'h0: tx_data = {7'h00, ds_r.st[sig_r]};
				2'h1: tx_data = {3'h0, ds_r.q[sig_r][12:8]};
				2'h2: tx_data = ds_r.q[sig_r][7:0];
				default: tx_data = 8'h00;
			endcase
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	dest_fixed_a: assert property ((st_r == S_HDR) && (idx_r == 7'h00) |-> tx_data == 8'h01)
		else $error("dest first octet wrong");
	pair_state_a: assert property ((st_r == S_DATA) && (part_r == 2'h0) |-> tx_data[7:1] == 7'h00)
		else $error("state byte not boolean");
	frame_len_a: assert property (tx_last |-> idx_r == 7'(NBYTES-1))
		else $error("frame length wrong");
	hold_data_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("byte not held");
endmodule : iosp_tx_ser

// file: hdl/iosp_rx_sub.sv
`timescale 1ns/1ps
// ==========================================
// commanding frame parser
module iosp_rx_sub (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                rx_valid,
	input  wire logic [7:0]          rx_data,
	input  wire logic                rx_last,
	input  wire logic [15:0]         src_id,
	output iosp_pkg::iosp_cmd_t      cmd,
	output logic                    ok,
	output logic                    rej
);
	import iosp_pkg::*;
	logic [RX_B*8-1:0] buf_r;
	logic [RX_B*8-1:0] nb;
	logic [4:0]        cnt_r;
	logic              good;
	iosp_cmd_t         dec;

	assign nb   = {buf_r[RX_B*8-9:0], rx_data};
	// wrong length or a foreign publisher is dropped
	assign good = (cnt_r == 5'(RX_B-1)) && (nb[RX_B*8-1 -: 16] == src_id);

	// outputs one to four in order, state byte then two quality bytes
	always_comb begin
		for (int k = 0; k < NOUT; k++) begin
			dec.st[k] = |nb[(RX_B-3-3*k)*8 +: 8];
			dec.q[k]  = nb[(RX_B-5-3*k)*8 +: QW];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_r <= '0;
			cnt_r <= 5'h00;
			cmd   <= '0;
			ok    <= 1'b0;
			rej   <= 1'b0;
		end else begin
			ok  <= rx_valid && rx_last && good;
			rej <= rx_valid && rx_last && !good;
			if (rx_valid) begin
				buf_r <= nb;
				cnt_r <= rx_last ? 5'h00 : ((cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h01);
				if (rx_last && good) cmd <= dec;
			end
		end
	end
endmodule : iosp_rx_sub

// file: tb/iosp_ied_model.sv
`timescale 1ns/1ps
// ==========================================
// commanding device and frame sink on the far side
module iosp_ied_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       slow,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last,
	output logic [7:0]      fr [73],
	output int              n_fr,
	output int              n_bad
);
	import iosp_pkg::*;
	int idx;
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h5A;
		rx_last  = 1'b0;
	end
	// sink keeps the last frame; a slow sink stalls every other cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			idx      <= 0;
			n_fr     <= 0;
			n_bad    <= 0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready) begin
				fr[idx] <= tx_data;
				idx     <= tx_last ? 0 : idx + 1;
				if (tx_last) begin
					n_fr  <= n_fr + 1;
					n_bad <= n_bad + int'(idx != NBYTES - 1);
				end
			end
		end
	end
	// commanding frame: source id, then state byte and quality per output
	task automatic send_cmd(input logic [15:0] src, input logic [3:0] st,
		input logic [3:0] qb, input int len);
		logic [7:0]  b [RX_B];
		logic [15:0] q;
		b[0] = src[15:8];
		b[1] = src[7:0];
		for (int i = 0; i < NOUT; i++) begin
			q = qb[i] ? 16'(QUAL_INV) : 16'(QUAL_GOOD);
			b[2 + 3 * i] = {7'h00, st[i]};
			b[3 + 3 * i] = q[15:8];
			b[4 + 3 * i] = q[7:0];
		end
		for (int i = 0; i < len; i++) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_data  <= b[i];
			rx_last  <= (i == len - 1);
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
		rx_data  <= ~rx_data; // released line shows no stale byte
	endtask : send_cmd
endmodule : iosp_ied_model

// file: tb/testbench.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the status publisher
module testbench;
	import iosp_pkg::*;
	localparam int CPM = 10;
	localparam logic [15:0] W1 [6] = '{16'h0, 16'h0, 16'h0, 16'h0FA0, 16'h0, 16'h0};
	localparam logic [15:0] W2 [6] = '{16'hABCD, 16'hA123, 16'h1111, 16'h0BB8, 16'h2222,
		16'h3333};
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        hok     = 1'b1;
	logic [13:0] di      = 14'h0;
	logic [13:0] df      = 14'h0;
	logic        slow    = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
	logic [7:0]  tx_data, rx_data;
	logic [3:0]  do_pin;
	logic [7:0]  fr [73];
	int          n_fr, n_bad;
	int          n_fail  = 0;
	int          n_tests = 0;
	always #5 pclk = ~pclk;
	iosp_top #(.CYC_PER_MS(CPM)) u_iosp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .health_ok_pin(hok),
		.di_pin(di), .di_fault_pin(df), .do_pin(do_pin), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .irq(irq));
	iosp_ied_model u_iosp_ied_model (.pclk(pclk), .presetn(presetn), .slow(slow),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .fr(fr),
		.n_fr(n_fr), .n_bad(n_bad));
	// ==========================================
	// checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================
	// apb master: request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			chk(32'h0, 32'h1);
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		@(negedge pclk); // let the write land before outputs are looked at
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask : rdc
	// waits for the next complete frame and returns the cycles waited
	task automatic wait_frame(output int cyc);
		int n0;
		n0 = n_fr;
		cyc = 0;
		while (n_fr == n0 && cyc < 40000) begin
			@(posedge pclk);
			cyc++;
		end
		if (n_fr == n0) begin
			chk(32'h0, 32'h1);
			tally_and_finish();
		end
		@(negedge pclk);
	endtask : wait_frame
	// expected frame built from the settings and the pin levels
	task automatic chk_frame(input logic [15:0] w [6], input logic hl, input logic [13:0] dv,
		input logic [13:0] dq, input logic [3:0] dov, input logic act);
		logic [7:0]    e [NBYTES];
		logic [QW-1:0] q;
		logic          s;
		for (int i = 0; i < 4; i++) e[i] = DEST_FIXED[31 - 8 * i -: 8];
		for (int i = 0; i < 6; i++) begin
			e[4 + 2 * i] = w[i][15:8];
			e[5 + 2 * i] = w[i][7:0];
		end
		for (int i = 0; i < NSIG; i++) begin
			s = (i == 0) ? hl : (i <= NIN) ? dv[i - 1] : dov[i - 1 - NIN];
			q = (i == 0) ? QUAL_GOOD : (i <= NIN) ? (dq[i - 1] ? QUAL_INV : QUAL_GOOD) :
				(act ? QUAL_GOOD : QUAL_INV);
			e[HDR_B + 3 * i] = {7'h00, s};
			e[HDR_B + 3 * i + 1] = {3'b000, q[12:8]};
			e[HDR_B + 3 * i + 2] = q[7:0];
		end
		for (int i = 0; i < NBYTES; i++) chk(32'(fr[i]), 32'(e[i]));
		chk(32'(n_bad), 32'h0);
	endtask : chk_frame
	// ==========================================
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (90000) @(posedge pclk);
		chk(32'h0, 32'h1);
		tally_and_finish();
	end
	// ==========================================
	// main sequence
	initial begin
		int          c;
		logic [31:0] r;
		logic        e;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFS_CTRL, 32'h1);
		rdc(OFS_HBEAT, 32'(HB_RST));
		rdc(OFS_TAL, 32'(TAL_RST));
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk(32'(e), 32'h1);
		// first frame leaves before the health pin is through its synchroniser
		wait_frame(c);
		wait_frame(c);
		chk_frame(W1, 1'b1, 14'h0, 14'h0, 4'h0, 1'b0);
		// frame-sent interrupt raised, then cleared by writing one
		wr(OFS_IMASK, 32'h1);
		chk(32'(irq), 32'h1);
		wr(OFS_ISTAT, 32'h1);
		chk(32'(irq), 32'h0);
		wr(OFS_CTRL, 32'h0);
		rdc(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_DEST, 32'h0000ABCD);
		wr(OFS_VLAN, 32'h01230005);
		wr(OFS_CBREF, 32'h1111);
		wr(OFS_TAL, 32'h0BB8);
		wr(OFS_DSREF, 32'h2222);
		wr(OFS_MSGID, 32'h3333);
		wr(OFS_SUBSRC, 32'h1234);
		// input change under a stalling sink: sent at once with new settings
		@(posedge pclk);
		slow <= 1'b1;
		di   <= 14'h2001;
		df   <= 14'h0100;
		wait_frame(c);
		chk_frame(W2, 1'b1, 14'h2001, 14'h0100, 4'h0, 1'b0);
		@(posedge pclk);
		slow <= 1'b0;
		hok  <= 1'b0;
		wait_frame(c);
		chk_frame(W2, 1'b0, 14'h2001, 14'h0100, 4'h0, 1'b0);
		wait_frame(c);
		chk(32'(c >= 19980 && c <= 20010), 32'h1);
		// shorter heartbeat setting; the first interval may be in flight
		wr(OFS_HBEAT, 32'd20);
		wait_frame(c);
		wait_frame(c);
		chk(32'(c >= 185 && c <= 210), 32'h1);
		wr(OFS_HBEAT, 32'd2000);
		// commanding frame: a bad-quality output stays off
		u_iosp_ied_model.send_cmd(16'h1234, 4'b1011, 4'b0010, RX_B);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk(32'(do_pin), 32'h9);
		wait_frame(c);
		chk_frame(W2, 1'b0, 14'h2001, 14'h0100, 4'b1001, 1'b1);
		rdc(OFS_STAT, 32'h91);
		// foreign source and a short frame are both refused
		wr(OFS_ISTAT, 32'hF);
		u_iosp_ied_model.send_cmd(16'h4321, 4'b0110, 4'b0000, RX_B);
		u_iosp_ied_model.send_cmd(16'h1234, 4'b0110, 4'b0000, RX_B - 1);
		repeat (4) @(posedge pclk);
		chk(32'(do_pin), 32'h9);
		apb(1'b0, OFS_ISTAT, 32'h0, r, e);
		chk(32'(r[IRQ_REJ]), 32'h1);
		// a valid frame midway restarts the supervision timer
		u_iosp_ied_model.send_cmd(16'h1234, 4'b0011, 4'b0000, RX_B);
		repeat (15000) @(posedge pclk);
		u_iosp_ied_model.send_cmd(16'h1234, 4'b0011, 4'b0000, RX_B);
		wr(OFS_IMASK, 32'(1 << IRQ_TMO));
		wr(OFS_ISTAT, 32'hF);
		repeat (29780) @(posedge pclk);
		chk(32'(do_pin), 32'h3);
		c = 0;
		while (do_pin !== 4'h0 && c < 400) begin
			@(posedge pclk);
			c++;
		end
		@(negedge pclk);
		chk(32'(do_pin), 32'h0);
		chk(32'(irq), 32'h1);
		apb(1'b0, OFS_STAT, 32'h0, r, e);
		chk(32'(r[0]), 32'h0);
		wr(OFS_ISTAT, 32'(1 << IRQ_TMO));
		chk(32'(irq), 32'h0);
		repeat (200) @(posedge pclk);
		chk(32'(do_pin), 32'h0);
		u_iosp_ied_model.send_cmd(16'h1234, 4'b1100, 4'b0000, RX_B);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk(32'(do_pin), 32'hC);
		apb(1'b0, OFS_STAT, 32'h0, r, e);
		chk(32'(r[0]), 32'h1);
		tally_and_finish();
	end
endmodule : testbench
